// [common/iobsr_pkg.sv]
package iobsr_pkg;
    // word addresses on the client side (decimal register numbers)
    localparam logic [19:0] DYN_BASE = 20'd410001;
    localparam logic [19:0] DYN_LAST = 20'd410020;
    localparam logic [19:0] STAT_BASE = 20'd37401;
    localparam logic [19:0] STAT_LAST = 20'd37560;
    localparam logic [19:0] STAT_ALT_BASE = 20'd419651;
    localparam logic [19:0] STAT_ALT_LAST = 20'd419810;
    // word index inside the dynamic data area
    localparam logic [4:0] IDX_GLOBAL_ERR = 5'h00;
    localparam logic [4:0] IDX_SLOT_ERR_LO = 5'h01;
    localparam logic [4:0] IDX_SLOT_ERR_HI = 5'h02;
    localparam logic [4:0] IDX_REBOOT_FLAGS = 5'h03;
    localparam logic [4:0] IDX_REBOOT_CNT_LO = 5'h04;
    localparam logic [4:0] IDX_REBOOT_CNT_HI = 5'h05;
    localparam logic [4:0] IDX_WDOG_TIMEOUT = 5'h06;
    // record layout of the slot status area
    localparam int REC_WORDS = 20;
    localparam logic [4:0] REC_FLAGS = 5'h00;
    localparam logic [4:0] REC_ERR = 5'h01;
    localparam logic [4:0] REC_WARN = 5'h02;
    localparam logic [4:0] REC_INFO = 5'h03;
    // field positions
    localparam int REBOOT_BIT = 0;
    localparam int SF_ERR_BIT = 0;
    localparam int SF_WARN_BIT = 1;
    localparam int SF_INFO_BIT = 2;
    localparam int SF_EXT_BIT = 4;
    // limits and codes
    localparam logic [15:0] WDOG_MAX_MS = 16'd10000;
    localparam logic [15:0] WDOG_RESET_MS = 16'h0000;
    localparam logic [15:0] CODE_NONE = 16'd0;
    localparam logic [15:0] CODE_CHAN_FAIL = 16'd121;
    localparam logic [15:0] CODE_UNUSED_AIN = 16'd122;
    localparam logic [15:0] CODE_BROKEN_XMTR = 16'd139;
    localparam logic [15:0] CODE_MULTI_FAIL = 16'd142;
    localparam logic [15:0] CODE_CFG_CHANGED = 16'd154;
    localparam logic [15:0] CODE_UNUSED_CH_FIRST = 16'd200;
    localparam logic [15:0] CODE_UNUSED_CH_LAST = 16'd216;
endpackage : iobsr_pkg

// [hw/iobsr_code_ram.sv]
`timescale 1ns/1ps
module iobsr_code_ram
    import iobsr_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int AW = 5
)(
    // clock
    input wire logic clk,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [15:0] wdata,
    // read side
    input wire logic [AW-1:0] raddr,
    output logic [15:0] rdata
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        rdata <= mem[raddr];
    end
endmodule : iobsr_code_ram

// [hw/iobsr_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - slot errors as two 16-bit bitmaps
// RL2 - any write to error words clears errors
// RL3 - reboot flag set after every reboot
// RL4 - write one to bit zero clears flag
// RL5 - flags bits one to fifteen reserved
// RL6 - reboot count read-only, low word first
// RL7 - count increments per restart, writes ignored; NRST clears it first, so it reads one after every restart
// RL8 - watchdog timeout 0..10000 ms, zero disables
// RL9 - slot flags show nonzero error/warning/info codes
// RL10 - slot flag bit four marks extended info
// RL11 - slot record twenty words, codes then reserved
// RL12 - code values for errors, warnings, info
// RL13 - codes 200..216 name unused channel
// RL14 - slot area mirrored at alternate range
module iobsr_top
    import iobsr_pkg::*;
#(
    parameter int SLOTS = 8,
    parameter int SW = 3
)(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // client word access
    input wire logic REQ_RD,
    input wire logic REQ_WR,
    input wire logic [19:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    output logic [15:0] RSP_RDATA,
    output logic RSP_VALID,
    output logic RSP_ERR,
    // module side code updates
    input wire logic CODE_WR,
    input wire logic [SW-1:0] CODE_SLOT,
    input wire logic [1:0] CODE_KIND,
    input wire logic [15:0] CODE_VALUE,
    input wire logic [SLOTS-1:0] SLOT_EXT_INFO,
    input wire logic [15:0] GLOBAL_ERR_IN,
    input wire logic GLOBAL_ERR_SET,
    // watchdog and status out
    output logic [15:0] WDOG_TIMEOUT_MS,
    output logic WDOG_ENABLE,
    output logic [31:0] REBOOT_COUNT
);
    localparam int RAW = SW + 2;

    logic [15:0] global_err_q;
    logic [31:0] slot_err_q;
    logic reboot_flag_q;
    logic [31:0] reboot_cnt_q;
    logic [15:0] wdog_q;
    logic [SLOTS-1:0] err_nz_q, warn_nz_q, info_nz_q;
    logic [SLOTS-1:0] ext_sync1_q, ext_sync2_q, ext_sync3_q, ext_q;
    logic started_q;

    // address decode
    logic in_dyn, in_stat, in_alt;
    logic [19:0] dyn_off, stat_off;
    logic [4:0] dyn_idx;
    logic [19:0] rec_slot20, rec_word20;
    logic [SW-1:0] rd_slot;
    logic [4:0] rd_word;
    logic slot_ok;

    always_comb
    begin
        in_dyn = (REQ_ADDR >= DYN_BASE) && (REQ_ADDR <= DYN_LAST);
        in_stat = (REQ_ADDR >= STAT_BASE) && (REQ_ADDR <= STAT_LAST);
        in_alt = (REQ_ADDR >= STAT_ALT_BASE) && (REQ_ADDR <= STAT_ALT_LAST);
        dyn_off = REQ_ADDR - DYN_BASE;
        dyn_idx = dyn_off[4:0];
        // RL14 alternate mirror range
        stat_off = in_alt ? (REQ_ADDR - STAT_ALT_BASE) : (REQ_ADDR - STAT_BASE);
        // RL11 twenty word records
        rec_slot20 = stat_off / 20'(REC_WORDS);
        rec_word20 = stat_off % 20'(REC_WORDS);
        rd_slot = rec_slot20[SW-1:0];
        rd_word = rec_word20[4:0];
        slot_ok = rec_slot20 < 20'(SLOTS);
    end

    logic wr_dyn;
    assign wr_dyn = REQ_WR && in_dyn;

    // cold start marker, one pass per reset release
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            started_q <= 1'b0;
        end
        else
        begin
            started_q <= 1'b1;
        end
    end

    // RL2 any write to error words clears errors
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            global_err_q <= CODE_NONE;
        end
        else if (GLOBAL_ERR_SET)
        begin
            global_err_q <= GLOBAL_ERR_IN;
        end
        else if (wr_dyn && (dyn_idx == IDX_GLOBAL_ERR || dyn_idx == IDX_SLOT_ERR_LO
                 || dyn_idx == IDX_SLOT_ERR_HI))
        begin
            global_err_q <= CODE_NONE;
        end
    end

    // RL1 one bit per slot
    logic [31:0] slot_err_set;
    genvar g;
    generate
        for (g = 0; g < 32; g++)
        begin : g_err
            if (g < SLOTS)
            begin : g_live
                assign slot_err_set[g] = CODE_WR && (CODE_KIND == 2'(REC_ERR))
                    && (CODE_SLOT == SW'(g)) && (CODE_VALUE != CODE_NONE);
            end
            else
            begin : g_none
                assign slot_err_set[g] = 1'b0;
            end
        end
    endgenerate

    logic err_clear;
    assign err_clear = wr_dyn && (dyn_idx == IDX_GLOBAL_ERR || dyn_idx == IDX_SLOT_ERR_LO
                       || dyn_idx == IDX_SLOT_ERR_HI);

    // RL2 clear, new error wins
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            slot_err_q <= 32'h0000_0000;
        end
        else
        begin
            slot_err_q <= (err_clear ? 32'h0000_0000 : slot_err_q) | slot_err_set;
        end
    end

    // RL3 set after reboot
    // RL4 write one clears
    // RL5 upper bits ignored
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            reboot_flag_q <= 1'b1;
        end
        else if (wr_dyn && dyn_idx == IDX_REBOOT_FLAGS && REQ_WDATA[REBOOT_BIT])
        begin
            reboot_flag_q <= 1'b0;
        end
    end

    // RL7 count each restart; NRST clears it first, so it reads one after every restart
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            reboot_cnt_q <= 32'h0000_0000;
        end
        else if (!started_q)
        begin
            reboot_cnt_q <= reboot_cnt_q + 32'h0000_0001;
        end
    end

    // RL8 clamp range, zero disables
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wdog_q <= WDOG_RESET_MS;
        end
        else if (wr_dyn && dyn_idx == IDX_WDOG_TIMEOUT)
        begin
            wdog_q <= (REQ_WDATA > WDOG_MAX_MS) ? WDOG_MAX_MS : REQ_WDATA;
        end
    end

    // code storage per slot and kind
    logic code_we;
    logic [RAW-1:0] code_waddr, code_raddr;
    logic [15:0] code_rdata;
    assign code_we = CODE_WR && (CODE_KIND != 2'(REC_FLAGS)) && (32'(CODE_SLOT) < SLOTS);
    assign code_waddr = {CODE_SLOT, CODE_KIND};
    assign code_raddr = {rd_slot, rd_word[1:0]};

    iobsr_code_ram #(
        .DEPTH(SLOTS * 4),
        .AW(RAW)
    ) u_codes (
        .clk(SYS_CLK),
        .we(code_we),
        .waddr(code_waddr),
        .wdata(CODE_VALUE),
        .raddr(code_raddr),
        .rdata(code_rdata)
    );

    // RL9 nonzero code indications
    // RL12 code zero means none
    generate
        for (g = 0; g < SLOTS; g++)
        begin : g_nz
            always_ff @(posedge SYS_CLK or negedge NRST)
            begin
                if (!NRST)
                begin
                    err_nz_q[g] <= 1'b0;
                    warn_nz_q[g] <= 1'b0;
                    info_nz_q[g] <= 1'b0;
                end
                else if (CODE_WR && CODE_SLOT == SW'(g))
                begin
                    if (CODE_KIND == 2'(REC_ERR))
                    begin
                        err_nz_q[g] <= CODE_VALUE != CODE_NONE;
                    end
                    if (CODE_KIND == 2'(REC_WARN))
                    begin
                        warn_nz_q[g] <= CODE_VALUE != CODE_NONE;
                    end
                    if (CODE_KIND == 2'(REC_INFO))
                    begin
                        info_nz_q[g] <= CODE_VALUE != CODE_NONE;
                    end
                end
            end
        end
    endgenerate

    // extended info pins synchronised
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ext_sync1_q <= '0;
            ext_sync2_q <= '0;
            ext_sync3_q <= '0;
            ext_q <= '0;
        end
        else
        begin
            ext_sync1_q <= SLOT_EXT_INFO;
            ext_sync2_q <= ext_sync1_q;
            ext_sync3_q <= ext_sync2_q;
            ext_q <= (ext_sync2_q & ext_sync3_q) | (ext_q & (ext_sync2_q | ext_sync3_q));
        end
    end

    // read pipeline, matches ram latency
    logic rd_p_q, rd_stat_q, rd_ok_q;
    logic [15:0] rd_dyn_q, flags_q;
    logic [4:0] rd_word_q;

    logic [15:0] dyn_word;
    logic [15:0] slot_flags;
    always_comb
    begin
        dyn_word = 16'h0000;
        unique case (dyn_idx)
            IDX_GLOBAL_ERR: dyn_word = global_err_q;
            IDX_SLOT_ERR_LO: dyn_word = slot_err_q[15:0];
            IDX_SLOT_ERR_HI: dyn_word = slot_err_q[31:16];
            IDX_REBOOT_FLAGS: dyn_word = {15'h0, reboot_flag_q};
            // RL6 low word first
            IDX_REBOOT_CNT_LO: dyn_word = reboot_cnt_q[15:0];
            IDX_REBOOT_CNT_HI: dyn_word = reboot_cnt_q[31:16];
            IDX_WDOG_TIMEOUT: dyn_word = wdog_q;
            default: dyn_word = 16'h0000;
        endcase
        slot_flags = 16'h0000;
        if (slot_ok)
        begin
            // RL10 extended info bit
            slot_flags[SF_ERR_BIT] = err_nz_q[rd_slot];
            slot_flags[SF_WARN_BIT] = warn_nz_q[rd_slot];
            slot_flags[SF_INFO_BIT] = info_nz_q[rd_slot];
            slot_flags[SF_EXT_BIT] = ext_q[rd_slot];
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rd_p_q <= 1'b0;
            rd_stat_q <= 1'b0;
            rd_ok_q <= 1'b0;
            rd_dyn_q <= 16'h0000;
            flags_q <= 16'h0000;
            rd_word_q <= 5'h00;
        end
        else
        begin
            rd_p_q <= REQ_RD || REQ_WR;
            rd_stat_q <= in_stat || in_alt;
            rd_ok_q <= in_dyn || ((in_stat || in_alt) && (slot_ok || REQ_WR));
            rd_dyn_q <= dyn_word;
            flags_q <= slot_flags;
            rd_word_q <= rd_word;
        end
    end

    // RL11 reserved words read zero
    // RL13 channel codes passed through
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RSP_RDATA <= 16'h0000;
            RSP_VALID <= 1'b0;
            RSP_ERR <= 1'b0;
        end
        else
        begin
            RSP_VALID <= rd_p_q;
            RSP_ERR <= rd_p_q && !rd_ok_q;
            if (!rd_stat_q)
            begin
                RSP_RDATA <= rd_dyn_q;
            end
            else if (rd_word_q == REC_FLAGS)
            begin
                RSP_RDATA <= flags_q;
            end
            else if (rd_word_q <= REC_INFO)
            begin
                RSP_RDATA <= code_rdata;
            end
            else
            begin
                RSP_RDATA <= 16'h0000;
            end
        end
    end

    // watchdog and counter outputs
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            WDOG_TIMEOUT_MS <= WDOG_RESET_MS;
            WDOG_ENABLE <= 1'b0;
            REBOOT_COUNT <= 32'h0000_0000;
        end
        else
        begin
            WDOG_TIMEOUT_MS <= wdog_q;
            WDOG_ENABLE <= wdog_q != WDOG_RESET_MS;
            REBOOT_COUNT <= reboot_cnt_q;
        end
    end
endmodule : iobsr_top

// [test/iobsr_top_asserts.sv]
`timescale 1ns/1ps
module iobsr_top_asserts
    import iobsr_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // client access
    input wire logic REQ_RD,
    input wire logic REQ_WR,
    input wire logic [19:0] REQ_ADDR,
    input wire logic [15:0] RSP_RDATA,
    input wire logic RSP_VALID,
    input wire logic RSP_ERR,
    // module side and status
    input wire logic CODE_WR,
    input wire logic [15:0] WDOG_TIMEOUT_MS,
    input wire logic WDOG_ENABLE,
    input wire logic [31:0] REBOOT_COUNT
);
    logic [1:0] age_q;
    logic req;
    assign req = REQ_RD | REQ_WR;
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    rsp_timing_a: assert property (req |-> ##2 RSP_VALID)
        else $error("no response two cycles after request");
    rsp_cause_a: assert property (RSP_VALID |-> $past(req, 2))
        else $error("response without request");
    err_unmapped_a: assert property (req && REQ_ADDR == DYN_LAST + 20'h1 |-> ##2 RSP_ERR)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (REQ_RD && REQ_ADDR >= DYN_BASE && REQ_ADDR <= DYN_BASE
        + 20'h6 |-> ##2 !RSP_ERR) else $error("mapped read refused");
    wdog_enable_a: assert property (WDOG_ENABLE == (WDOG_TIMEOUT_MS != 16'h0000))
        else $error("watchdog enable does not follow timeout");
    wdog_clamp_a: assert property (WDOG_TIMEOUT_MS <= WDOG_MAX_MS)
        else $error("watchdog timeout above range");
    count_hold_a: assert property (age_q == 2'h3 |-> $stable(REBOOT_COUNT))
        else $error("reboot count changed without restart");
    count_low_a: assert property (REQ_RD && REQ_ADDR == DYN_BASE + 20'h4 |->
        ##2 RSP_RDATA == REBOOT_COUNT[15:0]) else $error("count low word wrong");
    flags_rsvd_a: assert property (REQ_RD && REQ_ADDR == DYN_BASE + 20'h3 |->
        ##2 RSP_RDATA[15:1] == 15'h0000) else $error("reserved flag bits set");
    err_clear_a: assert property ((REQ_WR && REQ_ADDR == DYN_BASE + 20'h1 && !CODE_WR)
        ##1 (!CODE_WR)[*2] ##1 (REQ_RD && REQ_ADDR == DYN_BASE + 20'h1 && !CODE_WR)
        |-> ##2 RSP_RDATA == 16'h0000) else $error("slot errors not cleared by write");
    slot_rsvd_a: assert property (REQ_RD && REQ_ADDR == STAT_BASE |->
        ##2 RSP_RDATA[7:5] == 3'h0 && !RSP_RDATA[3]) else $error("reserved slot flag set");
    count_rd_c: cover property (REQ_RD && REQ_ADDR == DYN_BASE + 20'h4);
    clear_c: cover property (REQ_WR && REQ_ADDR == DYN_BASE + 20'h1);
    unmapped_c: cover property (RSP_ERR);
endmodule : iobsr_top_asserts

// [test/iobsr_client_model.sv]
`timescale 1ns/1ps
module iobsr_client_model
(
    // clock
    input wire logic clk,
    // request side
    output logic rd = 1'b0,
    output logic wr = 1'b0,
    output logic [19:0] addr = 20'h0,
    output logic [15:0] wdata = 16'h0,
    // answer side
    input wire logic [15:0] rdata,
    input wire logic valid,
    input wire logic err
);
    logic [15:0] last_q;
    logic err_q;
    logic to_q = 1'b0;
    // one word transfer, request held across its taking edge
    task automatic xfer(input logic w, input logic [19:0] a, input logic [15:0] d);
        int i;
        @(negedge clk);
        rd = !w;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        rd = 1'b0;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
        for (i = 0; i < 4 && valid !== 1'b1; i++)
            @(negedge clk);
        to_q = valid !== 1'b1;
        last_q = rdata;
        err_q = err;
    endtask : xfer
    task automatic clear_reboot();
        xfer(1'b1, 20'd410004, 16'h0001);
    endtask : clear_reboot
endmodule : iobsr_client_model

// [test/iobsr_top_tb_top.sv]
`timescale 1ns/1ps
module iobsr_top_tb_top
    import iobsr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic req_rd, req_wr;
    logic [19:0] req_addr;
    logic [15:0] req_wdata, rsp_rdata, wdog_timeout_ms;
    logic rsp_valid, rsp_err, wdog_enable;
    logic code_wr = 1'b0;
    logic [2:0] code_slot = 3'h0;
    logic [1:0] code_kind = 2'h0;
    logic [15:0] code_value = 16'h0;
    logic [7:0] slot_ext_info = 8'h00;
    logic [15:0] global_err_in = 16'h0;
    logic global_err_set = 1'b0;
    logic [31:0] reboot_count;
    int n_errors = 0;
    int n_tests = 0;
    int i;
    logic [15:0] codes [8] = '{CODE_NONE, CODE_CHAN_FAIL, CODE_UNUSED_AIN, CODE_BROKEN_XMTR,
        CODE_MULTI_FAIL, CODE_CFG_CHANGED, CODE_UNUSED_CH_FIRST, CODE_UNUSED_CH_LAST};
    always #25 sys_clk = ~sys_clk;
    iobsr_top iobsr_top_inst (.SYS_CLK(sys_clk), .NRST(nrst), .REQ_RD(req_rd),
        .REQ_WR(req_wr), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_RDATA(rsp_rdata),
        .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err), .CODE_WR(code_wr), .CODE_SLOT(code_slot),
        .CODE_KIND(code_kind), .CODE_VALUE(code_value), .SLOT_EXT_INFO(slot_ext_info),
        .GLOBAL_ERR_IN(global_err_in), .GLOBAL_ERR_SET(global_err_set),
        .WDOG_TIMEOUT_MS(wdog_timeout_ms), .WDOG_ENABLE(wdog_enable),
        .REBOOT_COUNT(reboot_count));
    iobsr_client_model iobsr_client_model_inst (.clk(sys_clk), .rd(req_rd), .wr(req_wr),
        .addr(req_addr), .wdata(req_wdata), .rdata(rsp_rdata), .valid(rsp_valid),
        .err(rsp_err));
    task automatic report_and_stop();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [19:0] a, input logic [15:0] exp);
        iobsr_client_model_inst.xfer(1'b0, a, 16'h0000);
        if (iobsr_client_model_inst.to_q)
        begin
            n_errors++;
            report_and_stop();
        end
        else
        begin
            check(iobsr_client_model_inst.last_q, exp);
        end
    endtask : rd
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        iobsr_client_model_inst.xfer(1'b1, a, d);
        if (iobsr_client_model_inst.to_q)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask : wr
    task automatic code(input logic [2:0] s, input logic [1:0] k, input logic [15:0] v);
        @(negedge sys_clk);
        code_wr = 1'b1;
        code_slot = s;
        code_kind = k;
        code_value = v;
        @(negedge sys_clk);
        code_wr = 1'b0;
    endtask : code
    initial
    begin
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        rd(DYN_BASE + 20'h3, 16'h0001);
        rd(DYN_BASE + 20'h4, 16'h0001);
        rd(DYN_BASE + 20'h5, 16'h0000);
        check(reboot_count, 32'h1);
        wr(DYN_BASE + 20'h4, 16'h1234);
        rd(DYN_BASE + 20'h4, 16'h0001);
        wr(DYN_BASE + 20'h3, 16'hfffe);
        rd(DYN_BASE + 20'h3, 16'h0001);
        iobsr_client_model_inst.clear_reboot();
        rd(DYN_BASE + 20'h3, 16'h0000);
        wr(DYN_BASE + 20'h6, WDOG_MAX_MS);
        rd(DYN_BASE + 20'h6, WDOG_MAX_MS);
        check(wdog_enable, 1'b1);
        wr(DYN_BASE + 20'h6, WDOG_MAX_MS + 16'h1);
        rd(DYN_BASE + 20'h6, WDOG_MAX_MS);
        check(wdog_timeout_ms, WDOG_MAX_MS);
        wr(DYN_BASE + 20'h6, 16'h0000);
        check(wdog_enable, 1'b0);
        for (i = 0; i < 8; i++)
            code(i[2:0], 2'h1, codes[i]);
        code(3'h3, 2'h2, CODE_BROKEN_XMTR);
        code(3'h3, 2'h3, CODE_UNUSED_CH_FIRST + 16'hc);
        for (i = 0; i < 8; i++)
        begin
            rd(STAT_BASE + 20'(i * REC_WORDS) + 20'h1, codes[i]);
            rd(STAT_ALT_BASE + 20'(i * REC_WORDS) + 20'h1, codes[i]);
            rd(STAT_BASE + 20'(i * REC_WORDS), {13'h0, i == 3, i == 3, codes[i] != 0});
            rd(STAT_BASE + 20'(i * REC_WORDS) + 20'h4, 16'h0000);
        end
        rd(STAT_BASE + 20'h3e, CODE_BROKEN_XMTR);
        rd(STAT_BASE + 20'h3f, 16'hd4);
        rd(DYN_BASE + 20'h1, 16'h00fe);
        rd(DYN_BASE + 20'h2, 16'h0000);
        wr(STAT_BASE + 20'h15, 16'h0000);
        rd(STAT_BASE + 20'h15, CODE_CHAN_FAIL);
        slot_ext_info = 8'h01;
        repeat (5) @(negedge sys_clk);
        rd(STAT_BASE, 16'h0010);
        wr(DYN_BASE + 20'h1, 16'h5a5a);
        rd(DYN_BASE + 20'h1, 16'h0000);
        @(negedge sys_clk);
        global_err_in = CODE_CFG_CHANGED;
        global_err_set = 1'b1;
        @(negedge sys_clk);
        global_err_set = 1'b0;
        rd(DYN_BASE, CODE_CFG_CHANGED);
        wr(DYN_BASE + 20'h2, 16'h0000);
        rd(DYN_BASE, 16'h0000);
        @(negedge sys_clk);
        nrst = 1'b0;
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        rd(DYN_BASE + 20'h3, 16'h0001);
        wr(DYN_LAST + 20'h1, 16'h1234);
        check(iobsr_client_model_inst.err_q, 1'b1);
        iobsr_client_model_inst.xfer(1'b0, DYN_LAST + 20'h1, 16'h0000);
        if (iobsr_client_model_inst.to_q)
            n_errors++;
        check(iobsr_client_model_inst.err_q, 1'b1);
        report_and_stop();
    end
endmodule : iobsr_top_tb_top
bind iobsr_top iobsr_top_asserts iobsr_top_asserts_inst (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .REQ_RD(REQ_RD), .REQ_WR(REQ_WR), .REQ_ADDR(REQ_ADDR), .RSP_RDATA(RSP_RDATA),
    .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR), .CODE_WR(CODE_WR),
    .WDOG_TIMEOUT_MS(WDOG_TIMEOUT_MS), .WDOG_ENABLE(WDOG_ENABLE), .REBOOT_COUNT(REBOOT_COUNT));
